/* hdl/fault_if.sv */
/*
 * Carrier between the stream top and its error status unit.
 * Assumes one clock domain shared by both ends.
 */
`timescale 1ns/10ps
`include "sess_defs.svh"

interface fault_if;
    logic [`ERR_NUM-1:0] set_evt;   // Fault event per bit
    logic [`ERR_NUM-1:0] active;    // Fault still pending
    logic [`ERR_NUM-1:0] mask;      // Forwarding enables
    logic [`ERR_NUM-1:0] ack;       // Host acknowledges
    logic [`ERR_NUM-1:0] status;    // Sticky flags

    modport top  (output set_evt, active, mask, ack, input status);
    modport unit (input set_evt, active, mask, ack, output status);
endinterface

/* hdl/fault_status.sv */
/*
 * Sticky error status flags with forward mask and acknowledge.
 * Assumes the top drives events, levels, mask and acknowledges.
 */
`timescale 1ns/10ps
`include "sess_defs.svh"

module fault_status (
    input  wire logic mclk_i,   // System clock
    input  wire logic rst_n_i,  // Async reset, active low
    fault_if.unit     flt       // Fault carrier
);

    logic [`ERR_NUM-1:0] status_q;

    // ****************************************
    // Sticky flags
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < `ERR_NUM; gi++) begin : g_flag
            always_ff @(posedge mclk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    status_q[gi] <= 1'b0;
                end else if (flt.set_evt[gi] && flt.mask[gi]) begin
                    status_q[gi] <= 1'b1;
                end else if (flt.ack[gi] && !flt.active[gi]) begin
                    status_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    assign flt.status = status_q;

endmodule // fault_status

/* hdl/sess_bridge.sv */
/*
 * Error status reporting and segmented stream bridge of a serial
 * interface module, facing the host over cyclic registers.
 * Assumes serial receive bytes and fault levels synchronous to
 * mclk_i, and a host that keeps its side of the handshake.
 */
// Notes on behaviour
// - Eight-bit forward mask, bits 0-3 report enables
// - Eight-bit status, bits 0-3 faults, rest zero
// - Detected error stays set until acknowledged
// - Full receive buffer drops data, flags overflow
// - Eight-bit acknowledge, bits 0-3 per error
// - Acknowledge clears only when error no longer active
// - Segments carry at most 63 bytes, one control byte
// - Control byte holds length and message end
// - A sequence never exceeds its window size
// - Window size set separately per direction
// - Window bytes used only on explicit acceptance
// - Direction synchronised before data; counters polled
// - Sender fills window, then increments counter
// - Receiver appends window, echoes counter as ack
// - Each sequence acknowledged; disturbance just stalls
// - With forward, counter jump of two stops acks
// - Receiver parses control bytes rebuilding messages
// - Control byte: length 0-5, next 6, end 7
// - Window sizes limited to 3 to 27 bytes
`timescale 1ns/10ps
`include "sess_defs.svh"

module sess_bridge #(
    parameter int WIN_BYTES = `WIN_MAX,   // Window register count
    parameter int BUF_DEPTH = `BUF_DEPTH  // Receive buffer bytes
) (
    input  wire logic                   mclk_i,               // Clock
    input  wire logic                   rst_n_i,              // Reset
    input  wire logic                   start_fault_i,        // Start
    input  wire logic                   stop_fault_i,         // Stop
    input  wire logic                   parity_fault_i,       // Parity
    input  wire logic [7:0]             rx_data_i,            // Ser byte
    input  wire logic                   rx_valid_i,           // Byte strb
    input  wire logic                   rx_end_i,             // Msg end
    input  wire logic [7:0]             error_forward_mask_i, // Mask
    input  wire logic [7:0]             error_acknowledge_i,  // Acks
    output logic      [7:0]             error_status_flags_o, // Flags
    input  wire logic [7:0]             tx_window_bytes_i,    // Out sz
    input  wire logic [7:0]             rx_window_bytes_i,    // In sz
    input  wire logic                   forward_enable_i,     // Fwd opt
    input  wire logic [7:0]             host_seq_status_i,    // Host seq
    input  wire logic [WIN_BYTES*8-1:0] tx_window_i,          // H to M
    output logic      [7:0]             module_seq_status_o,  // Mod seq
    output logic      [WIN_BYTES*8-1:0] rx_window_o,          // M to H
    output logic      [7:0]             msg_data_o,           // Msg byte
    output logic                        msg_valid_o,          // Strobe
    output logic                        msg_last_o            // Msg end
);

    localparam int AW = $clog2(BUF_DEPTH);

    // ****************************************
    // Window size limits
    // ****************************************
    function automatic logic [4:0] clamp_win(input logic [7:0] v);
        logic [4:0] r;
        r = v[4:0];
        if (v < 8'(`WIN_MIN)) begin
            r = `WIN_MIN;
        end else if (v > 8'(WIN_BYTES)) begin
            r = 5'(WIN_BYTES);
        end
        return r;
    endfunction

    logic [4:0] tx_len;
    logic [4:0] rx_len;
    logic [5:0] seg_cap;

    assign tx_len  = clamp_win(tx_window_bytes_i);
    assign rx_len  = clamp_win(rx_window_bytes_i);
    assign seg_cap = 6'(rx_len - 5'h01);

    // ****************************************
    // Host status byte fields
    // ****************************************
    logic [2:0] host_issue_count;
    logic       host_tx_sync;
    logic [2:0] host_rx_ack_mirror;
    logic       host_rx_ready;

    assign host_issue_count   = host_seq_status_i[`SEQ_CNT_LSB +: 3];
    assign host_tx_sync       = host_seq_status_i[`SEQ_SYNC_BIT];
    assign host_rx_ack_mirror = host_seq_status_i[`SEQ_ACK_LSB +: 3];
    assign host_rx_ready      = host_seq_status_i[`SEQ_READY_BIT];

    // ****************************************
    // Receive buffer
    // ****************************************
    logic [8:0]  buf_mem [BUF_DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic        buf_full;
    logic        buf_empty;
    logic        buf_pop;
    logic [8:0]  buf_head;
    logic        drop_evt;

    assign buf_empty = (wr_ptr == rd_ptr);
    assign buf_full  = (wr_ptr[AW] != rd_ptr[AW]) &&
                       (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    assign buf_head  = buf_mem[rd_ptr[AW-1:0]];
    assign drop_evt  = rx_valid_i && buf_full;

    always_ff @(posedge mclk_i) begin
        if (rx_valid_i && !buf_full) begin
            buf_mem[wr_ptr[AW-1:0]] <= {rx_end_i, rx_data_i};
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr <= '0;
        end else if (rx_valid_i && !buf_full) begin
            wr_ptr <= wr_ptr + 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_ptr <= '0;
        end else if (buf_pop) begin
            rd_ptr <= rd_ptr + 1'b1;
        end
    end

    // ****************************************
    // Error status unit
    // ****************************************
    fault_if flt ();

    assign flt.set_evt = {drop_evt, parity_fault_i, stop_fault_i,
                          start_fault_i};
    assign flt.active  = {buf_full, parity_fault_i, stop_fault_i,
                          start_fault_i};
    assign flt.mask    = error_forward_mask_i[`ERR_NUM-1:0];
    assign flt.ack     = error_acknowledge_i[`ERR_NUM-1:0];

    fault_status u_fault_status (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .flt     (flt.unit)
    );

    assign error_status_flags_o = {4'h0, flt.status};

    // ****************************************
    // Host to module direction: receiver
    // ****************************************
    sess_pkg::parse_state_t pstate;
    logic [2:0] out_ack;
    logic       out_sync;
    logic       out_stalled;
    logic [4:0] pidx;
    logic [5:0] seg_left;
    logic       seg_last;
    logic       seg_next_here;
    logic [2:0] out_gap;
    logic [7:0] tx_byte;

    assign out_gap = host_issue_count - out_ack;
    assign tx_byte = tx_window_i[{pidx, 3'b000} +: 8];

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_sync    <= 1'b0;
            out_ack     <= `SEQ_CNT_RESET;
            out_stalled <= 1'b0;
        end else if (!host_tx_sync) begin
            out_sync    <= 1'b0;
            out_stalled <= 1'b0;
        end else if (!out_sync) begin
            out_sync <= 1'b1;
            out_ack  <= host_issue_count;
        end else if (pstate == sess_pkg::P_DONE) begin
            out_ack <= out_ack + 3'h1;
        end else if (forward_enable_i && out_gap == 3'h2) begin
            out_stalled <= 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pstate        <= sess_pkg::P_IDLE;
            pidx          <= 5'h00;
            seg_left      <= 6'h00;
            seg_last      <= 1'b0;
            seg_next_here <= 1'b0;
        end else if (!host_tx_sync || !out_sync) begin
            pstate   <= sess_pkg::P_IDLE;
            seg_left <= 6'h00;
        end else begin
            case (pstate)
                sess_pkg::P_IDLE: begin
                    // Accept only a single step of the counter
                    if (out_gap == 3'h1 && !out_stalled) begin
                        pidx   <= 5'h00;
                        pstate <= (seg_left != 6'h00) ?
                                  sess_pkg::P_DATA : sess_pkg::P_CTRL;
                    end
                end
                sess_pkg::P_CTRL: begin
                    if (pidx >= tx_len) begin
                        pstate <= sess_pkg::P_DONE;
                    end else begin
                        seg_left      <= tx_byte[`CB_LEN_MSB:0];
                        seg_next_here <= tx_byte[`CB_NEXT_BIT];
                        seg_last      <= tx_byte[`CB_LAST_BIT];
                        pidx          <= pidx + 5'h01;
                        pstate        <= sess_pkg::P_DATA;
                    end
                end
                sess_pkg::P_DATA: begin
                    if (seg_left == 6'h00) begin
                        pstate <= seg_next_here ?
                                  sess_pkg::P_CTRL : sess_pkg::P_DONE;
                    end else if (pidx >= tx_len) begin
                        pstate <= sess_pkg::P_DONE;
                    end else begin
                        seg_left <= seg_left - 6'h01;
                        pidx     <= pidx + 5'h01;
                    end
                end
                sess_pkg::P_DONE: begin
                    pstate <= sess_pkg::P_IDLE;
                end
                default: begin
                    pstate <= sess_pkg::P_IDLE;
                end
            endcase
        end
    end

    // Rebuilt message bytes toward the serial transmitter
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            msg_data_o  <= 8'h00;
            msg_valid_o <= 1'b0;
            msg_last_o  <= 1'b0;
        end else if (pstate == sess_pkg::P_DATA && out_sync &&
                     host_tx_sync && seg_left != 6'h00 &&
                     pidx < tx_len) begin
            msg_data_o  <= tx_byte;
            msg_valid_o <= 1'b1;
            msg_last_o  <= seg_last && (seg_left == 6'h01);
        end else begin
            msg_valid_o <= 1'b0;
            msg_last_o  <= 1'b0;
        end
    end

    // ****************************************
    // Module to host direction: sender
    // ****************************************
    sess_pkg::send_state_t sstate;
    logic [2:0]             in_count;
    logic                   in_sync;
    logic [4:0]             widx;
    logic [5:0]             seg_len;
    logic                   fill_last;
    logic                   in_active;
    logic                   win_free;
    logic [WIN_BYTES*8-1:0] win_q;

    assign in_active = in_sync && host_rx_ready;
    assign win_free  = (host_rx_ack_mirror == in_count);
    assign buf_pop   = (sstate == sess_pkg::S_FILL) && in_active &&
                       !buf_empty && (seg_len != seg_cap) &&
                       (seg_len != `SEG_MAX);

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            in_sync <= 1'b0;
        end else begin
            in_sync <= 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sstate    <= sess_pkg::S_IDLE;
            in_count  <= `SEQ_CNT_RESET;
            widx      <= 5'h00;
            seg_len   <= 6'h00;
            fill_last <= 1'b0;
            win_q     <= '0;
        end else if (!in_active) begin
            sstate <= sess_pkg::S_IDLE;
        end else begin
            case (sstate)
                sess_pkg::S_IDLE: begin
                    // Refill only after the host echoed the counter
                    if (win_free && !buf_empty) begin
                        widx      <= 5'h01;
                        seg_len   <= 6'h00;
                        fill_last <= 1'b0;
                        sstate    <= sess_pkg::S_FILL;
                    end
                end
                sess_pkg::S_FILL: begin
                    if (buf_pop) begin
                        win_q[{widx, 3'b000} +: 8] <= buf_head[7:0];
                        widx    <= widx + 5'h01;
                        seg_len <= seg_len + 6'h01;
                        if (buf_head[8]) begin
                            fill_last <= 1'b1;
                            sstate    <= sess_pkg::S_ISSUE;
                        end
                    end else begin
                        sstate <= sess_pkg::S_ISSUE;
                    end
                end
                sess_pkg::S_ISSUE: begin
                    win_q[7:0] <= {fill_last, 1'b0, seg_len};
                    in_count   <= in_count + 3'h1;
                    sstate     <= sess_pkg::S_IDLE;
                end
                default: begin
                    sstate <= sess_pkg::S_IDLE;
                end
            endcase
        end
    end

    // Window bytes change only while the host may not read them
    assign rx_window_o = win_q;

    assign module_seq_status_o = {out_sync, out_ack, in_sync,
                                  in_count};

endmodule // sess_bridge

/* hdl/sess_defs.svh */
/*
 * Constants of the error status and segmented stream block:
 * field positions, limits and reset values.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef SESS_DEFS_SVH
`define SESS_DEFS_SVH

// ****************************************
// Error bit positions
// ****************************************
`define ERR_START_BIT    0
`define ERR_STOP_BIT     1
`define ERR_PARITY_BIT   2
`define ERR_OVERFLOW_BIT 3
`define ERR_NUM          4
`define ERR_RESET        4'h0

// ****************************************
// Sequence status byte fields
// ****************************************
`define SEQ_CNT_LSB      0
`define SEQ_SYNC_BIT     3
`define SEQ_ACK_LSB      4
`define SEQ_READY_BIT    7
`define SEQ_CNT_RESET    3'h0

// ****************************************
// Control byte fields and window limits
// ****************************************
`define CB_LEN_MSB       5
`define CB_NEXT_BIT      6
`define CB_LAST_BIT      7
`define SEG_MAX          6'h3f
`define WIN_MIN          5'h03
`define WIN_MAX          27
`define BUF_DEPTH        4096

`endif

/* hdl/sess_pkg.sv */
/*
 * Types of the error status and segmented stream block.
 * Assumes nothing of its surroundings.
 */
package sess_pkg;

    typedef enum logic [1:0] {
        P_IDLE = 2'b00,
        P_CTRL = 2'b01,
        P_DATA = 2'b10,
        P_DONE = 2'b11
    } parse_state_t;

    typedef enum logic [1:0] {
        S_IDLE  = 2'b00,
        S_FILL  = 2'b01,
        S_ISSUE = 2'b10
    } send_state_t;

endpackage

/* verification/host_stub.sv */
/*
 * Host model: drives its sequence status byte and transmit window,
 * echoes module sequences after a chosen lag.
 * Assumes the bench calls its tasks just after a clock edge.
 */
`timescale 1ns/10ps

module host_stub (
    input  wire logic         mclk_i,    // Clock
    input  wire logic         rst_n_i,   // Reset
    input  wire logic [7:0]   mod_seq_i, // Module seq status
    input  wire logic [215:0] win_i,     // Module to host window
    output logic      [7:0]   seq_o,     // Host seq status
    output logic      [215:0] win_o      // Host to module window
);
    // ****************************************
    // Host state and echo
    // ****************************************
    logic [2:0]  cnt    = 3'h0;
    logic [2:0]  mirror = 3'h0;
    logic        sync   = 1'b0;
    logic        ready  = 1'b0;
    logic        rst_seen = 1'b1;
    int          lag    = 0;
    int          wt     = 0;
    logic [23:0] got[$];

    initial win_o = '0;
    assign seq_o = {ready, mirror, sync, cnt};

    initial forever begin
        @(posedge mclk_i);
        // Reset seen at the edge, before the bench moves it
        rst_seen = !rst_n_i;
        #1;
        if (rst_seen) begin
            mirror = 3'h0;
            wt = 0;
        end else if (ready && mod_seq_i[2:0] != mirror) begin
            if (wt < lag) begin
                wt++;
            end else begin
                got.push_back(win_i[23:0]);
                mirror = mod_seq_i[2:0];
                wt = 0;
            end
        end
    end

    task automatic sync_on(input logic on);
        @(posedge mclk_i);
        #1 sync = on;
    endtask

    task automatic send(input logic [23:0] w, input logic [2:0] step);
        for (int n = 0; n < 200 && mod_seq_i[6:4] != cnt; n++) begin
            @(posedge mclk_i);
            #1;
        end
        win_o[23:0] = w;
        @(posedge mclk_i);
        #1 cnt = cnt + step;
    endtask
endmodule // host_stub

/* verification/sess_bridge_props.sv */
/*
 * Checker of the error flag and stream ports of sess_bridge.
 * Assumes a bind from the bench onto the top module.
 */
`timescale 1ns/10ps

module sess_bridge_props #(
    parameter int WIN_BYTES = 27                   // Window register count
) (
    input wire logic                   mclk_i,               // Clock
    input wire logic                   rst_n_i,              // Reset
    input wire logic                   start_fault_i,        // Start
    input wire logic                   stop_fault_i,         // Stop
    input wire logic [7:0]             error_forward_mask_i, // Mask
    input wire logic [7:0]             error_acknowledge_i,  // Acks
    input wire logic [7:0]             error_status_flags_o, // Flags
    input wire logic                   forward_enable_i,     // Fwd opt
    input wire logic [7:0]             host_seq_status_i,    // Host seq
    input wire logic [7:0]             module_seq_status_o,  // Mod seq
    input wire logic [WIN_BYTES*8-1:0] rx_window_o           // M to H
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    wire logic [2:0] m_cnt = module_seq_status_o[2:0];
    wire logic [2:0] m_ack = module_seq_status_o[6:4];
    wire logic [2:0] h_cnt = host_seq_status_i[2:0];

    AST_UPPER_ZERO: assert property (error_status_flags_o[7:4] == 4'h0)
        else $error("status upper bits set");
    AST_SET_START: assert property (start_fault_i && error_forward_mask_i[0]
        |=> error_status_flags_o[0]) else $error("start flag not set");
    AST_MASKED: assert property ($rose(error_status_flags_o[1])
        |-> $past(stop_fault_i) && $past(error_forward_mask_i[1]))
        else $error("stop flag set without cause");
    AST_HOLD: assert property (error_status_flags_o[2] &&
        !error_acknowledge_i[2] |=> error_status_flags_o[2])
        else $error("parity flag lost");
    AST_ACK_ACTIVE: assert property (error_status_flags_o[0] &&
        start_fault_i |=> error_status_flags_o[0])
        else $error("flag cleared while fault active");
    AST_ACK_CLEAR: assert property (error_status_flags_o[1] &&
        error_acknowledge_i[1] && !stop_fault_i |=> !error_status_flags_o[1])
        else $error("acknowledged flag kept");
    AST_SYNC_ACK: assert property ($rose(host_seq_status_i[3])
        |=> module_seq_status_o[7]) else $error("sync not answered");
    AST_ACK_STEP: assert property ($changed(m_ack) &&
        $past(module_seq_status_o[7]) && module_seq_status_o[7]
        |-> m_ack == $past(m_ack) + 3'h1) else $error("ack step wrong");
    AST_ACK_DONE: assert property (module_seq_status_o[7] &&
        host_seq_status_i[3] && !forward_enable_i && h_cnt == m_ack + 3'h1
        |-> ##[1:64] m_ack == h_cnt) else $error("sequence not acked");
    AST_CNT_STEP: assert property ($changed(m_cnt)
        |-> m_cnt == $past(m_cnt) + 3'h1) else $error("count step wrong");
    AST_WIN_HOLD: assert property (host_seq_status_i[6:4] != m_cnt
        |=> $stable(rx_window_o)) else $error("window changed unacked");
endmodule // sess_bridge_props

/* verification/sess_bridge_tb.sv */
/*
 * Self-checking bench of sess_bridge with the host model.
 * Assumes a 27 byte window and a four byte receive buffer.
 */
`timescale 1ns/10ps

module sess_bridge_tb;
    // ****************************************
    // Signals, table and instances
    // ****************************************
    logic         mclk_i, rst_n_i, start_fault_i, stop_fault_i;
    logic         parity_fault_i, rx_valid_i, rx_end_i, forward_enable_i;
    logic         msg_valid_o, msg_last_o;
    logic [7:0]   rx_data_i, error_forward_mask_i, error_acknowledge_i;
    logic [7:0]   error_status_flags_o, tx_window_bytes_i, rx_window_bytes_i;
    logic [7:0]   host_seq_status_i, module_seq_status_o, msg_data_o;
    logic [215:0] tx_window_i, rx_window_o;
    int           miscompares = 0;
    int           checks_done = 0;
    int           cycles = 0;
    logic [8:0]   msgs[$];
    logic [8:0]   exp_msg [4] = '{9'h0aa, 9'h1bb, 9'h0cc, 9'h1dd};
    typedef struct packed {logic [2:0] f; logic [7:0] m, a, e;} row_t;
    row_t rows [9] = '{'{3'h1, 8'h01, 8'h00, 8'h01},
        '{3'h0, 8'h01, 8'h00, 8'h01}, '{3'h1, 8'h01, 8'h01, 8'h01},
        '{3'h0, 8'h01, 8'h01, 8'h00}, '{3'h2, 8'h00, 8'h00, 8'h00},
        '{3'h2, 8'hf2, 8'h00, 8'h02}, '{3'h4, 8'h0f, 8'h00, 8'h06},
        '{3'h0, 8'h0f, 8'h0f, 8'h00}, '{3'h7, 8'hf0, 8'h00, 8'h00}};

    sess_bridge #(.WIN_BYTES(27), .BUF_DEPTH(4)) DUT (
        .mclk_i, .rst_n_i, .start_fault_i, .stop_fault_i, .parity_fault_i,
        .rx_data_i, .rx_valid_i, .rx_end_i, .error_forward_mask_i,
        .error_acknowledge_i, .error_status_flags_o, .tx_window_bytes_i,
        .rx_window_bytes_i, .forward_enable_i, .host_seq_status_i,
        .tx_window_i, .module_seq_status_o, .rx_window_o, .msg_data_o,
        .msg_valid_o, .msg_last_o);
    host_stub host (.mclk_i, .rst_n_i, .mod_seq_i(module_seq_status_o),
        .win_i(rx_window_o), .seq_o(host_seq_status_i), .win_o(tx_window_i));

    initial begin
        mclk_i = 1'b0;
        forever #10 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) begin
        if (msg_valid_o) msgs.push_back({msg_last_o, msg_data_o});
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            end_sim();
        end
    end

    task automatic chk(input string n, input logic [23:0] e, g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic step;
        @(posedge mclk_i);
        #1;
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        rst_n_i = 1'b0;
        {parity_fault_i, stop_fault_i, start_fault_i} = 3'h0;
        {rx_valid_i, rx_end_i, forward_enable_i} = 3'h0;
        rx_data_i = 8'h00;
        error_forward_mask_i = 8'h00;
        error_acknowledge_i = 8'h00;
        tx_window_bytes_i = 8'h03;
        rx_window_bytes_i = 8'h01;
        repeat (16) @(posedge mclk_i);
        #1 rst_n_i = 1'b1;
        step();
        chk("seq after reset", 24'h08, module_seq_status_o);
        foreach (rows[i]) begin
            {parity_fault_i, stop_fault_i, start_fault_i} = rows[i].f;
            error_forward_mask_i = rows[i].m;
            error_acknowledge_i = rows[i].a;
            step();
            chk("flags", rows[i].e, error_status_flags_o);
        end
        error_forward_mask_i = 8'h08;
        foreach (exp_msg[i]) begin
            rx_valid_i = 1'b1;
            rx_data_i = 8'h11 * 8'(i + 1);
            rx_end_i = (i == 3);
            step();
        end
        rx_data_i = 8'h55;
        rx_end_i = 1'b0;
        step();
        rx_valid_i = 1'b0;
        error_acknowledge_i = 8'h08;
        step();
        step();
        chk("overflow flag", 24'h08, error_status_flags_o);
        host.lag = 3;
        host.ready = 1'b1;
        for (int n = 0; n < 200 && host.got.size() < 2; n++) step();
        chk("window one", 24'h221102, host.got[0]);
        chk("window two", 24'h443382, host.got[1]);
        chk("overflow cleared", 24'h00, error_status_flags_o);
        error_acknowledge_i = 8'h00;
        rx_window_bytes_i = 8'hff;
        foreach (exp_msg[i]) begin
            rx_valid_i = 1'b1;
            rx_data_i = 8'h11 * 8'(i + 5);
            rx_end_i = (i == 3);
            step();
        end
        rx_valid_i = 1'b0;
        rx_end_i = 1'b0;
        for (int n = 0; n < 200 && host.got.size() < 3; n++) step();
        chk("window three", 24'h665584, host.got[2]);
        host.sync_on(1'b1);
        host.send(24'hbbaa82, 3'h1);
        tx_window_bytes_i = 8'h00;
        host.send(24'h5acc01, 3'h1);
        host.send(24'h5add81, 3'h1);
        for (int n = 0; n < 200 && module_seq_status_o[6:4] != 3'h3; n++)
            step();
        chk("msg count", 24'h4, 24'(msgs.size()));
        foreach (exp_msg[i]) chk("msg byte", exp_msg[i], msgs[i]);
        forward_enable_i = 1'b1;
        host.send(24'h5aee81, 3'h2);
        repeat (10) step();
        host.cnt = 3'h4;
        repeat (70) step();
        chk("stalled ack", 24'h3, module_seq_status_o[6:4]);
        host.sync_on(1'b0);
        forward_enable_i = 1'b0;
        host.sync_on(1'b1);
        step();
        chk("resync ack", 24'h4, module_seq_status_o[6:4]);
        chk("msg count", 24'h4, 24'(msgs.size()));
        host.sync_on(1'b0);
        rst_n_i = 1'b0;
        step();
        chk("flags in reset", 24'h0, error_status_flags_o);
        chk("seq in reset", 24'h0, module_seq_status_o);
        rst_n_i = 1'b1;
        step();
        chk("seq after reset", 24'h08, module_seq_status_o);
        end_sim();
    end
endmodule // sess_bridge_tb

bind sess_bridge sess_bridge_props #(.WIN_BYTES(WIN_BYTES)) u_props (
    .mclk_i, .rst_n_i, .start_fault_i, .stop_fault_i, .error_forward_mask_i,
    .error_acknowledge_i, .error_status_flags_o, .forward_enable_i,
    .host_seq_status_i, .module_seq_status_o, .rx_window_o);
